/* File: common/srm_pkg.sv */
package srm_pkg;

    // Serial frame layout: read flag, address, data, most significant bit first.
    localparam int ADDR_W = 15;
    localparam int DATA_W = 8;
    localparam logic [4:0] HDR_LAST_BIT = 5'h0f;
    localparam logic [4:0] FRAME_LAST_BIT = 5'h17;
    localparam logic [4:0] FRAME_BITS = 5'h18;
    localparam int RW_FLAG_POS = 15;

    // Register offsets.
    localparam logic [14:0] OFS_REFERENCE_COUNTER = 15'h001f;
    localparam logic [14:0] OFS_DIAGNOSTIC_OUTPUT_CONTROL = 15'h0020;
    localparam logic [14:0] OFS_REFERENCE_PATH_CONTROL = 15'h0022;
    localparam logic [14:0] OFS_OSCILLATOR_POWER_SELECT = 15'h0025;
    localparam logic [14:0] OFS_PUMP_BLEED_MAGNITUDE = 15'h0026;
    localparam logic [14:0] OFS_LOCK_DETECT_CONTROL = 15'h0027;

    // Values after reset and writable bit masks.
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [7:0] MASK_REFERENCE_COUNTER = 8'h1f;
    localparam logic [7:0] MASK_DIAGNOSTIC_OUTPUT_CONTROL = 8'hfc;
    localparam logic [7:0] MASK_FULL = 8'hff;

    // Field positions.
    localparam int REF_COUNT_MSB = 4;
    localparam int DIAG_SOURCE_LSB = 4;
    localparam int DIAG_ROUTING_BIT = 3;
    localparam int DIAG_LEVEL_BIT = 2;
    localparam int REF_DOUBLER_BIT = 5;
    localparam int REF_HALVER_BIT = 4;
    localparam int OSC_POWER_LSB = 0;
    localparam int LOCK_WINDOW_LSB = 6;
    localparam int LOCK_PRECISION_BIT = 5;
    localparam int GATED_BLEED_BIT = 4;

    // Diagnostic source codes.
    localparam logic [3:0] DIAG_HIGH_Z = 4'h0;
    localparam logic [3:0] DIAG_LOCK = 4'h1;
    localparam logic [3:0] DIAG_PUMP_UP = 4'h2;
    localparam logic [3:0] DIAG_PUMP_DOWN = 4'h3;
    localparam logic [3:0] DIAG_HALF_REF = 4'h4;
    localparam logic [3:0] DIAG_HALF_FB = 4'h5;
    localparam logic [3:0] DIAG_OSC_TEST = 4'h6;
    localparam logic [3:0] DIAG_CONST_HIGH = 4'h8;

    // Reference division ratio used for a programmed zero.
    localparam logic [5:0] REF_ZERO_RATIO = 6'h20;

    // Lock detect counts in phase detector cycles, base doubled per select step.
    localparam logic [13:0] LOCK_COUNT_BASE = 14'h0400;

    typedef struct packed {
        logic sclk;
        logic cs_n;
        logic mosi;
    } srm_spi_in_t;

    typedef struct packed {
        logic [4:0] ref_count;
        logic ref_doubler_enable;
        logic ref_halver_enable;
        logic [3:0] diag_source_select;
        logic diag_pin_routing;
        logic diag_level_select;
        logic [1:0] osc_power_select;
        logic [7:0] pump_bleed_magnitude;
        logic [1:0] lock_window_select;
        logic lock_precision;
        logic gated_bleed_enable;
    } srm_cfg_t;

endpackage

/* File: rtl/srm_lock_detect.sv */
`timescale 1ns/100ps
module srm_lock_detect (
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_rst,
    // Phase detector status
    input wire logic i_pfd_tick,
    input wire logic i_in_window,
    input wire logic [1:0] i_lock_cycle_count,
    // Lock status
    output logic o_lock
);
    import srm_pkg::*;

    logic [13:0] count_reg;
    logic [13:0] target;
    logic lock_reg;

    assign target = 14'(LOCK_COUNT_BASE << i_lock_cycle_count);
    assign o_lock = lock_reg;

    // Counts consecutive in-window cycles and drops lock on any miss.
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            count_reg <= 14'h0000;
            lock_reg <= 1'b0;
        end else if (i_pfd_tick) begin
            if (!i_in_window) begin
                count_reg <= 14'h0000;
                lock_reg <= 1'b0;
            end else if (!lock_reg) begin
                if (count_reg == 14'(target - 14'h0001)) begin
                    lock_reg <= 1'b1;
                end else begin
                    count_reg <= 14'(count_reg + 14'h0001);
                end
            end
        end
    end

    property p_lock_needs_count;
        @(posedge i_clock) disable iff (i_rst)
        $rose(lock_reg) |-> $past(i_pfd_tick && i_in_window && count_reg == 14'(target - 14'h0001));
    endproperty
    a_lock_needs_count: assert property (p_lock_needs_count) else $error("Lock rose early.");

    property p_miss_drops_lock;
        @(posedge i_clock) disable iff (i_rst)
        (i_pfd_tick && !i_in_window) |=> (!lock_reg && count_reg == 14'h0000);
    endproperty
    a_miss_drops_lock: assert property (p_miss_drops_lock) else $error("Lock held on miss.");

    c_lock_reached: cover property (@(posedge i_clock) disable iff (i_rst) $rose(lock_reg));
endmodule

/* File: rtl/srm_config_bank.sv */
`timescale 1ns/100ps
module srm_config_bank (
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_rst,
    // Serial host pins
    input srm_pkg::srm_spi_in_t i_spi,
    output logic o_sdo,
    output logic o_sdo_oe_n,
    // Synthesizer signals
    input wire logic i_ref_tick,
    input wire logic i_fb_tick,
    input wire logic i_pump_up,
    input wire logic i_pump_down,
    input wire logic i_osc_test,
    input wire logic i_pfd_tick,
    input wire logic i_phase_in_window,
    input wire logic [1:0] i_lock_cycle_count,
    // Configuration and status
    output srm_pkg::srm_cfg_t o_cfg,
    output logic o_ref_div_tick,
    output logic o_lock_detect,
    output logic o_diag_level_3v3
);
    import srm_pkg::*;

    function automatic logic [5:0] ref_ratio(input logic [4:0] field);
        ref_ratio = (field == 5'h00) ? REF_ZERO_RATIO : {1'b0, field};
    endfunction

    logic [2:0] sclk_sync_reg, cs_sync_reg, mosi_sync_reg;
    logic sclk_lvl_reg, cs_lvl_reg, mosi_lvl_reg;
    logic sclk_rise, sclk_fall;
    logic [4:0] bit_cnt_reg;
    logic [23:0] shift_reg, shift_next;
    logic rw_reg, rd_active_reg;
    logic [14:0] addr_reg;
    logic [7:0] rd_shift_reg;
    logic hdr_done, wr_commit;
    logic [7:0] ref_counter_reg, diag_ctrl_reg, ref_path_reg;
    logic [7:0] osc_power_reg, bleed_reg, lock_ctrl_reg;
    logic [5:0] ref_cnt_reg;
    logic halve_phase_reg, ref_div_tick_reg, half_ref_reg, half_fb_reg;
    logic div_event;
    logic lock;
    logic diag_value;
    logic sdo_reg, sdo_oe_n_reg;

    function automatic logic [7:0] read_reg(input logic [14:0] addr);
        case (addr)
            OFS_REFERENCE_COUNTER: read_reg = ref_counter_reg & MASK_REFERENCE_COUNTER;
            OFS_DIAGNOSTIC_OUTPUT_CONTROL: read_reg = diag_ctrl_reg & MASK_DIAGNOSTIC_OUTPUT_CONTROL;
            OFS_REFERENCE_PATH_CONTROL: read_reg = ref_path_reg;
            OFS_OSCILLATOR_POWER_SELECT: read_reg = osc_power_reg;
            OFS_PUMP_BLEED_MAGNITUDE: read_reg = bleed_reg;
            OFS_LOCK_DETECT_CONTROL: read_reg = lock_ctrl_reg;
            default: read_reg = 8'h00;
        endcase
    endfunction

    // Three-stage synchronisers; a level counts once stages two and three agree.
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            sclk_sync_reg <= 3'h0;
            cs_sync_reg <= 3'h7;
            mosi_sync_reg <= 3'h0;
        end else begin
            sclk_sync_reg <= {sclk_sync_reg[1:0], i_spi.sclk};
            cs_sync_reg <= {cs_sync_reg[1:0], i_spi.cs_n};
            mosi_sync_reg <= {mosi_sync_reg[1:0], i_spi.mosi};
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            sclk_lvl_reg <= 1'b0;
            cs_lvl_reg <= 1'b1;
            mosi_lvl_reg <= 1'b0;
        end else begin
            if (sclk_sync_reg[1] == sclk_sync_reg[2]) sclk_lvl_reg <= sclk_sync_reg[2];
            if (cs_sync_reg[1] == cs_sync_reg[2]) cs_lvl_reg <= cs_sync_reg[2];
            if (mosi_sync_reg[1] == mosi_sync_reg[2]) mosi_lvl_reg <= mosi_sync_reg[2];
        end
    end

    assign sclk_rise = !cs_lvl_reg && (sclk_sync_reg[1] == sclk_sync_reg[2])
                       && sclk_sync_reg[2] && !sclk_lvl_reg;
    assign sclk_fall = !cs_lvl_reg && (sclk_sync_reg[1] == sclk_sync_reg[2])
                       && !sclk_sync_reg[2] && sclk_lvl_reg;
    assign shift_next = {shift_reg[22:0], mosi_lvl_reg};
    assign hdr_done = sclk_rise && bit_cnt_reg == HDR_LAST_BIT;
    assign wr_commit = sclk_rise && bit_cnt_reg == FRAME_LAST_BIT && !rw_reg;

    // Frame receiver: header of read flag and address, then one data byte.
    always_ff @(posedge i_clock) begin
        if (i_rst || cs_lvl_reg) begin
            bit_cnt_reg <= 5'h00;
            shift_reg <= 24'h000000;
            rw_reg <= 1'b0;
            addr_reg <= 15'h0000;
        end else if (sclk_rise && bit_cnt_reg != FRAME_BITS) begin
            shift_reg <= shift_next;
            bit_cnt_reg <= 5'(bit_cnt_reg + 5'h01);
            if (hdr_done) begin
                rw_reg <= shift_next[RW_FLAG_POS];
                addr_reg <= shift_next[14:0];
            end
        end
    end

    // Read-back shifter, loaded at the end of a read header.
    always_ff @(posedge i_clock) begin
        if (i_rst || cs_lvl_reg) begin
            rd_shift_reg <= 8'h00;
            rd_active_reg <= 1'b0;
        end else if (hdr_done && shift_next[RW_FLAG_POS]) begin
            rd_shift_reg <= read_reg(shift_next[14:0]);
            rd_active_reg <= 1'b1;
        end else if (sclk_fall && rd_active_reg) begin
            rd_shift_reg <= {rd_shift_reg[6:0], 1'b0};
        end
    end

    // Register writes, masked so read-only reserved bits stay zero.
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            ref_counter_reg <= REG_RESET;
            diag_ctrl_reg <= REG_RESET;
            ref_path_reg <= REG_RESET;
            osc_power_reg <= REG_RESET;
            bleed_reg <= REG_RESET;
            lock_ctrl_reg <= REG_RESET;
        end else if (wr_commit) begin
            case (addr_reg)
                OFS_REFERENCE_COUNTER: ref_counter_reg <= shift_next[7:0] & MASK_REFERENCE_COUNTER;
                OFS_DIAGNOSTIC_OUTPUT_CONTROL: diag_ctrl_reg <= shift_next[7:0] & MASK_DIAGNOSTIC_OUTPUT_CONTROL;
                OFS_REFERENCE_PATH_CONTROL: ref_path_reg <= shift_next[7:0];
                OFS_OSCILLATOR_POWER_SELECT: osc_power_reg <= shift_next[7:0];
                OFS_PUMP_BLEED_MAGNITUDE: bleed_reg <= shift_next[7:0] & MASK_FULL;
                OFS_LOCK_DETECT_CONTROL: lock_ctrl_reg <= shift_next[7:0];
                default: ref_counter_reg <= ref_counter_reg;
            endcase
        end
    end

    always_comb begin
        o_cfg.ref_count = ref_counter_reg[REF_COUNT_MSB:0];
        o_cfg.ref_doubler_enable = ref_path_reg[REF_DOUBLER_BIT];
        o_cfg.ref_halver_enable = ref_path_reg[REF_HALVER_BIT];
        o_cfg.diag_source_select = diag_ctrl_reg[DIAG_SOURCE_LSB +: 4];
        o_cfg.diag_pin_routing = diag_ctrl_reg[DIAG_ROUTING_BIT];
        o_cfg.diag_level_select = diag_ctrl_reg[DIAG_LEVEL_BIT];
        o_cfg.osc_power_select = osc_power_reg[OSC_POWER_LSB +: 2];
        o_cfg.pump_bleed_magnitude = bleed_reg;
        o_cfg.lock_window_select = lock_ctrl_reg[LOCK_WINDOW_LSB +: 2];
        o_cfg.lock_precision = lock_ctrl_reg[LOCK_PRECISION_BIT];
        o_cfg.gated_bleed_enable = lock_ctrl_reg[GATED_BLEED_BIT];
    end

    assign o_diag_level_3v3 = diag_ctrl_reg[DIAG_LEVEL_BIT];

    // Reference divider with optional divide-by-two after it.
    assign div_event = i_ref_tick
                       && ref_cnt_reg == 6'(ref_ratio(ref_counter_reg[4:0]) - 6'h01);

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            ref_cnt_reg <= 6'h00;
            halve_phase_reg <= 1'b0;
            ref_div_tick_reg <= 1'b0;
            half_ref_reg <= 1'b0;
        end else begin
            ref_div_tick_reg <= 1'b0;
            if (div_event) begin
                ref_cnt_reg <= 6'h00;
                half_ref_reg <= !half_ref_reg;
                halve_phase_reg <= !halve_phase_reg;
                ref_div_tick_reg <= !ref_path_reg[REF_HALVER_BIT] || halve_phase_reg;
            end else if (i_ref_tick) begin
                ref_cnt_reg <= 6'(ref_cnt_reg + 6'h01);
            end
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            half_fb_reg <= 1'b0;
        end else if (i_fb_tick) begin
            half_fb_reg <= !half_fb_reg;
        end
    end

    assign o_ref_div_tick = ref_div_tick_reg;

    srm_lock_detect u_lock (
        .i_clock(i_clock),
        .i_rst(i_rst),
        .i_pfd_tick(i_pfd_tick),
        .i_in_window(i_phase_in_window),
        .i_lock_cycle_count(i_lock_cycle_count),
        .o_lock(lock)
    );

    assign o_lock_detect = lock;

    always_comb begin
        case (diag_ctrl_reg[DIAG_SOURCE_LSB +: 4])
            DIAG_LOCK: diag_value = lock;
            DIAG_PUMP_UP: diag_value = i_pump_up;
            DIAG_PUMP_DOWN: diag_value = i_pump_down;
            DIAG_HALF_REF: diag_value = half_ref_reg;
            DIAG_HALF_FB: diag_value = half_fb_reg;
            DIAG_OSC_TEST: diag_value = i_osc_test;
            DIAG_CONST_HIGH: diag_value = 1'b1;
            default: diag_value = 1'b0;
        endcase
    end

    // Output pin: diagnostic when routed, read-back during reads, else released.
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            sdo_reg <= 1'b0;
            sdo_oe_n_reg <= 1'b1;
        end else if (diag_ctrl_reg[DIAG_ROUTING_BIT]) begin
            sdo_reg <= diag_value;
            sdo_oe_n_reg <= 1'b0;
        end else if (rd_active_reg) begin
            sdo_reg <= rd_shift_reg[7];
            sdo_oe_n_reg <= 1'b0;
        end else begin
            sdo_reg <= 1'b0;
            sdo_oe_n_reg <= 1'b1;
        end
    end

    assign o_sdo = sdo_reg;
    assign o_sdo_oe_n = sdo_oe_n_reg;

    property p_reset_zero;
        @(posedge i_clock) i_rst |=> (o_cfg == '0 && o_sdo_oe_n);
    endproperty
    a_reset_zero: assert property (p_reset_zero) else $error("Not zero after reset.");

    property p_zero_ratio;
        @(posedge i_clock) disable iff (i_rst)
        (i_ref_tick && ref_counter_reg[4:0] == 5'h00 && ref_cnt_reg == 6'h1f)
            |=> (ref_cnt_reg == 6'h00 && half_ref_reg != $past(half_ref_reg));
    endproperty
    a_zero_ratio: assert property (p_zero_ratio) else $error("Zero field not 32.");

    property p_lock_routed;
        @(posedge i_clock) disable iff (i_rst)
        (diag_ctrl_reg[7:3] == 5'h03) |=> (o_sdo == $past(lock) && !o_sdo_oe_n);
    endproperty
    a_lock_routed: assert property (p_lock_routed) else $error("Lock not on pin.");

    property p_float_only_unrouted;
        @(posedge i_clock) disable iff (i_rst)
        $rose(o_sdo_oe_n) |-> $past(!diag_ctrl_reg[DIAG_ROUTING_BIT] && !rd_active_reg);
    endproperty
    a_float_only_unrouted: assert property (p_float_only_unrouted) else $error("Bad float.");

    property p_readback_drives;
        @(posedge i_clock) disable iff (i_rst)
        (rd_active_reg && !diag_ctrl_reg[DIAG_ROUTING_BIT])
            |=> (!o_sdo_oe_n && o_sdo == $past(rd_shift_reg[7]));
    endproperty
    a_readback_drives: assert property (p_readback_drives) else $error("No read-back.");

    property p_reserved_zero;
        @(posedge i_clock) disable iff (i_rst)
        wr_commit ##1 1'b1 |-> (ref_counter_reg[7:5] == 3'h0 && diag_ctrl_reg[1:0] == 2'h0);
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("Reserved bit set.");

    property p_bleed_write;
        @(posedge i_clock) disable iff (i_rst)
        (wr_commit && addr_reg == OFS_PUMP_BLEED_MAGNITUDE)
            |=> (o_cfg.pump_bleed_magnitude == $past(shift_next[7:0]));
    endproperty
    a_bleed_write: assert property (p_bleed_write) else $error("Bleed not stored.");

    property p_path_bits;
        @(posedge i_clock) disable iff (i_rst)
        (wr_commit && addr_reg == OFS_REFERENCE_PATH_CONTROL)
            |=> (o_cfg.ref_doubler_enable == $past(shift_next[5])
                 && o_cfg.ref_halver_enable == $past(shift_next[4]));
    endproperty
    a_path_bits: assert property (p_path_bits) else $error("Path bits wrong.");

    c_write_frame: cover property (@(posedge i_clock) disable iff (i_rst) wr_commit);
    c_read_frame: cover property (@(posedge i_clock) disable iff (i_rst) hdr_done && shift_next[15]);
    c_diag_routed: cover property (@(posedge i_clock) disable iff (i_rst)
        diag_ctrl_reg[DIAG_ROUTING_BIT] && !o_sdo_oe_n);
endmodule

/* File: verification/srm_host_model.sv */
`timescale 1ns/100ps
module srm_host_model (
    // Clock
    input wire logic i_clock,
    // Serial pins
    output srm_pkg::srm_spi_in_t o_spi,
    input wire logic i_sdo
);
    import srm_pkg::*;
    localparam int HALF = 10;
    initial o_spi = '{sclk: 1'h0, cs_n: 1'h1, mosi: 1'h0};
    task automatic wait_clk(input int n);
        repeat (n) @(posedge i_clock);
        #1;
    endtask
    // Sends nbits of a frame; fewer than 24 aborts it.
    // Read data is sampled before each fall, from the last header bit on.
    task automatic frame(input logic rd, input logic [14:0] a, input logic [7:0] wd,
                         input int nbits, output logic [7:0] rdat);
        logic [23:0] word;
        word = {rd, a, wd};
        rdat = 8'h00;
        o_spi.cs_n = 1'h0;
        for (int i = 0; i < nbits; i++) begin
            o_spi.mosi = word[23 - i];
            wait_clk(HALF);
            o_spi.sclk = 1'h1;
            wait_clk(HALF);
            if (i >= 15 && i < 23) rdat = {rdat[6:0], i_sdo};
            o_spi.sclk = 1'h0;
        end
        wait_clk(HALF);
        o_spi.cs_n = 1'h1;
        o_spi.mosi = ~o_spi.mosi;
        wait_clk(8);
    endtask
endmodule

/* File: verification/srm_config_bank_tb_top.sv */
`timescale 1ns/100ps
module srm_config_bank_tb_top;
    import srm_pkg::*;
    logic i_clock = 1'h0;
    logic i_rst = 1'h1;
    srm_spi_in_t spi;
    logic sdo, oe_n, div_tick, lock_det, lvl_3v3;
    wire sdo_pin;
    logic ref_tick = 1'h0, fb_tick = 1'h0, lvl = 1'h0, pfd_tick = 1'h0, in_win = 1'h0;
    logic [1:0] lock_cnt = 2'h0;
    srm_cfg_t cfg;
    logic [7:0] rd;
    int n_mismatch = 0;
    int checks_done = 0;
    logic [14:0] ofs [6] = '{OFS_REFERENCE_COUNTER, OFS_DIAGNOSTIC_OUTPUT_CONTROL,
        OFS_REFERENCE_PATH_CONTROL, OFS_OSCILLATOR_POWER_SELECT, OFS_PUMP_BLEED_MAGNITUDE,
        OFS_LOCK_DETECT_CONTROL};
    always #4 i_clock = ~i_clock;
    assign sdo_pin = oe_n ? ~sdo : sdo;
    srm_host_model host (.i_clock(i_clock), .o_spi(spi), .i_sdo(sdo_pin));
    srm_config_bank DUT (.i_clock(i_clock), .i_rst(i_rst), .i_spi(spi), .o_sdo(sdo),
        .o_sdo_oe_n(oe_n), .i_ref_tick(ref_tick), .i_fb_tick(fb_tick), .i_pump_up(lvl),
        .i_pump_down(lvl), .i_osc_test(lvl), .i_pfd_tick(pfd_tick),
        .i_phase_in_window(in_win), .i_lock_cycle_count(lock_cnt), .o_cfg(cfg),
        .o_ref_div_tick(div_tick), .o_lock_detect(lock_det), .o_diag_level_3v3(lvl_3v3));
    task automatic give_verdict;
        $display("Comparisons %0d, mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge i_clock);
        #1;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp, input string what);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error at %0t: %s got %b expected %b", $time, what, got, exp);
        end
    endtask
    task automatic wr(input logic [14:0] a, input logic [7:0] d);
        host.frame(1'h0, a, d, 24, rd);
    endtask
    task automatic rdr(input logic [14:0] a, input logic [7:0] exp);
        logic [7:0] v;
        host.frame(1'h1, a, 8'h00, 24, v);
        chk(v, exp, "read back");
    endtask
    task automatic t_reset;
        chk_bit(|cfg, 1'h0, "cfg after reset");
        chk_bit(oe_n, 1'h1, "pin released");
        chk_bit(lock_det, 1'h0, "lock after reset");
        for (int i = 0; i < 6; i++) rdr(ofs[i], REG_RESET);
    endtask
    task automatic t_regs;
        logic [7:0] wa [6] = '{8'hff, 8'hf7, 8'hff, 8'hff, 8'hff, 8'hff};
        logic [7:0] ea [6] = '{8'h1f, 8'hf4, 8'hff, 8'hff, 8'hff, 8'hff};
        logic [7:0] wb [6] = '{8'he0, 8'h03, 8'h10, 8'h02, 8'h73, 8'h90};
        logic [7:0] eb [6] = '{8'h00, 8'h00, 8'h10, 8'h02, 8'h73, 8'h90};
        for (int i = 0; i < 6; i++) wr(ofs[i], wa[i]);
        for (int i = 0; i < 6; i++) rdr(ofs[i], ea[i]);
        chk({cfg.ref_count, cfg.ref_doubler_enable, cfg.ref_halver_enable, 1'h0}, 8'hfe,
            "ref fields");
        chk({cfg.diag_source_select, cfg.diag_pin_routing, cfg.diag_level_select,
            cfg.osc_power_select}, 8'hf7, "diag fields");
        chk_bit(lvl_3v3, 1'h1, "level 3v3");
        chk(cfg.pump_bleed_magnitude, 8'hff, "bleed");
        chk({cfg.lock_window_select, cfg.lock_precision, cfg.gated_bleed_enable, 4'h0},
            8'hf0, "lock fields");
        wr(15'h0021, 8'hff);
        rdr(15'h0021, 8'h00);
        host.frame(1'h0, OFS_PUMP_BLEED_MAGNITUDE, 8'h11, 12, rd);
        rdr(OFS_PUMP_BLEED_MAGNITUDE, 8'hff);
        for (int i = 0; i < 6; i++) wr(ofs[i], wb[i]);
        for (int i = 0; i < 6; i++) rdr(ofs[i], eb[i]);
        chk({cfg.ref_doubler_enable, cfg.ref_halver_enable, cfg.diag_level_select,
            cfg.lock_window_select, cfg.lock_precision, cfg.gated_bleed_enable, 1'h0},
            8'h52, "fields");
        chk_bit(lvl_3v3, 1'h0, "level 1v8");
        chk({6'h00, cfg.osc_power_select}, 8'h02, "power");
    endtask
    task automatic ref_gap(output int g);
        int ticks;
        int seen;
        ticks = 0;
        seen = 0;
        g = 0;
        while (seen < 3 && ticks < 300) begin
            ref_tick = 1'h1;
            step(1);
            ref_tick = 1'h0;
            ticks++;
            repeat (3) begin
                if (div_tick === 1'h1) begin
                    seen++;
                    g = (seen == 3) ? ticks - g : ticks;
                end
                step(1);
            end
        end
    endtask
    task automatic t_refdiv;
        logic [7:0] dv [5] = '{8'h03, 8'h01, 8'h00, 8'h1f, 8'h03};
        logic [7:0] ex [5] = '{8'h03, 8'h01, 8'h20, 8'h1f, 8'h06};
        int g;
        for (int i = 0; i < 5; i++) begin
            wr(OFS_REFERENCE_PATH_CONTROL, (i == 4) ? 8'h10 : 8'h00);
            wr(OFS_REFERENCE_COUNTER, dv[i]);
            ref_gap(g);
            chk(8'(g), ex[i], "divide ratio");
        end
        wr(OFS_REFERENCE_PATH_CONTROL, 8'h00);
    endtask
    task automatic diag_lvl(input logic [3:0] c, input logic hi, input logic lo);
        wr(OFS_DIAGNOSTIC_OUTPUT_CONTROL, {c, 4'h8});
        lvl = 1'h1;
        step(3);
        chk_bit(oe_n, 1'h0, "pin driven");
        chk_bit(sdo, hi, "diag high");
        lvl = 1'h0;
        step(3);
        chk_bit(sdo, lo, "diag low");
    endtask
    task automatic diag_tog(input logic [3:0] c);
        logic prev;
        wr(OFS_DIAGNOSTIC_OUTPUT_CONTROL, {c, 4'h8});
        step(3);
        prev = sdo;
        fb_tick = 1'h1;
        ref_tick = 1'h1;
        step(1);
        fb_tick = 1'h0;
        ref_tick = 1'h0;
        step(3);
        chk_bit(sdo, ~prev, "diag toggle");
    endtask
    task automatic t_diag;
        wr(OFS_REFERENCE_COUNTER, 8'h01);
        diag_lvl(DIAG_PUMP_UP, 1'h1, 1'h0);
        diag_lvl(DIAG_PUMP_DOWN, 1'h1, 1'h0);
        diag_lvl(DIAG_OSC_TEST, 1'h1, 1'h0);
        diag_lvl(DIAG_CONST_HIGH, 1'h1, 1'h1);
        diag_lvl(DIAG_LOCK, 1'h0, 1'h0);
        diag_lvl(DIAG_HIGH_Z, 1'h0, 1'h0);
        diag_lvl(4'h7, 1'h0, 1'h0);
        diag_tog(DIAG_HALF_REF);
        diag_tog(DIAG_HALF_FB);
        wr(OFS_DIAGNOSTIC_OUTPUT_CONTROL, 8'h00);
        step(3);
        chk_bit(oe_n, 1'h1, "pin released");
    endtask
    task automatic pfd(input int n, input logic w);
        repeat (n) begin
            pfd_tick = 1'h1;
            in_win = w;
            step(1);
            pfd_tick = 1'h0;
            step(1);
        end
    endtask
    task automatic lock_run(input int n);
        pfd(n - 1, 1'h1);
        chk_bit(lock_det, 1'h0, "early lock");
        pfd(1, 1'h1);
        step(2);
        chk_bit(lock_det, 1'h1, "lock");
        chk_bit(sdo, 1'h1, "lock on pin");
        pfd(1, 1'h0);
        chk_bit(lock_det, 1'h0, "unlock");
    endtask
    task automatic t_lock;
        wr(OFS_DIAGNOSTIC_OUTPUT_CONTROL, 8'h18);
        lock_run(1024);
        pfd(600, 1'h1);
        pfd(1, 1'h0);
        lock_run(1024);
        lock_cnt = 2'h1;
        lock_run(2048);
        lock_cnt = 2'h3;
        lock_run(8192);
    endtask
    initial begin
        #720000;
        n_mismatch++;
        $display("Error at %0t: watchdog expired", $time);
        give_verdict();
    end
    initial begin
        repeat (2) @(posedge i_clock);
        #1;
        i_rst = 1'h0;
        t_reset();
        t_regs();
        t_refdiv();
        t_diag();
        t_lock();
        give_verdict();
    end
endmodule
